// *** logic/ior_out_cell.sv ***
// output and tri-state register path of one pad logic cell
//
// Summary of operation
// - sdr: one storage element drives pad
// - sdr element is flip-flop or latch
// - ddr: capture both inputs on rise
// - next fall: second value into fall stage
// - clock-driven mux alternates rise/fall stages
// - tri-state control registered, drives enable
// - paired cells give true and inverted outputs
`timescale 1ns/1ps
`default_nettype none
module ior_out_cell #(
  parameter int DEPTH = ior_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire ior_pkg::ior_mode_t mode,
  input wire logic comp_pair_en,
  input wire logic first_data_in,
  input wire logic second_data_in,
  input wire logic tristate_ctrl_in,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic out_hold,
  output logic pad_data_out,
  output logic pad_data_n_out,
  output logic pad_oe_n
);
  import ior_pkg::*;

  // ************************************************
  // parameter check
  // ************************************************
  generate
    if (DEPTH < 2) begin : g_bad_param
      $error("ior_out_cell needs a fifo depth of at least 2");
    end
  endgenerate

  // ************************************************
  // input buffering
  // ************************************************
  logic head_valid;
  logic [WORD_W-1:0] head;
  logic [WORD_W-1:0] in_word;
  logic pop;

  always_comb begin
    in_word = '0;
    in_word[BIT_FIRST] = first_data_in;
    in_word[BIT_SECOND] = second_data_in;
    in_word[BIT_TRI] = tristate_ctrl_in;
  end

  assign pop = head_valid & ~out_hold;

  ior_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(in_valid),
    .in_data(in_word),
    .in_ready(in_ready),
    .out_valid(head_valid),
    .out_data(head),
    .out_ready(~out_hold)
  );

  // ************************************************
  // rising edge stages
  // ************************************************
  typedef struct packed {
    logic rise_stage_reg;
    logic second_cap;
    logic tri_reg;
  } ior_rise_st_t;

  typedef struct packed {
    logic fall_stage_reg;
    logic latch_q;
  } ior_fall_st_t;

  ior_rise_st_t st_ff;
  ior_rise_st_t nxt_st;
  ior_fall_st_t fst_ff;
  ior_fall_st_t nxt_fst;
  logic lat_d;

  always_comb begin
    nxt_st = st_ff;
    if (pop) begin
      nxt_st.rise_stage_reg = head[BIT_FIRST];
      nxt_st.second_cap = head[BIT_SECOND];
      nxt_st.tri_reg = head[BIT_TRI];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff.rise_stage_reg <= RST_DATA;
      st_ff.second_cap <= RST_DATA;
      st_ff.tri_reg <= RST_TRI;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************
  // falling edge stages
  // ************************************************
  // latch is transparent while the clock is high
  assign lat_d = pop ? head[BIT_FIRST] : fst_ff.latch_q;

  always_comb begin
    nxt_fst = fst_ff;
    nxt_fst.fall_stage_reg = st_ff.second_cap;
    nxt_fst.latch_q = lat_d;
  end

  always_ff @(negedge core_clk) begin
    if (rst) begin
      fst_ff.fall_stage_reg <= RST_DATA;
      fst_ff.latch_q <= RST_DATA;
    end else begin
      fst_ff <= nxt_fst;
    end
  end

  // ************************************************
  // pad drive
  // ************************************************
  always_comb begin
    case (mode)
      IOR_SDR_FF: pad_data_out = st_ff.rise_stage_reg;
      IOR_SDR_LATCH: pad_data_out = core_clk ? lat_d : fst_ff.latch_q;
      IOR_DDR: pad_data_out = core_clk ? st_ff.rise_stage_reg : fst_ff.fall_stage_reg;
      default: pad_data_out = st_ff.rise_stage_reg;
    endcase
  end

  assign pad_data_n_out = comp_pair_en ? ~pad_data_out : 1'h0;
  assign pad_oe_n = st_ff.tri_reg;

  // ************************************************
  // assertions
  // ************************************************
  sequence s_pop_first;
    pop ##1 (st_ff.rise_stage_reg == $past(head[BIT_FIRST]));
  endsequence

  sequence s_pop_second;
    pop ##1 (st_ff.second_cap == $past(head[BIT_SECOND]));
  endsequence

  property p_sdr_ff;
    @(posedge core_clk) disable iff (rst)
      (mode == IOR_SDR_FF) |-> (pad_data_out == st_ff.rise_stage_reg);
  endproperty
  a_sdr_ff: assert property (p_sdr_ff) else $error("sdr output not from flip-flop");

  property p_sdr_latch;
    @(negedge core_clk) disable iff (rst)
      (mode == IOR_SDR_LATCH) |-> (pad_data_out == lat_d) ##1 (fst_ff.latch_q == $past(lat_d));
  endproperty
  a_sdr_latch: assert property (p_sdr_latch) else $error("latch output wrong");

  property p_capture;
    @(posedge core_clk) disable iff (rst)
      pop |-> s_pop_first and s_pop_second;
  endproperty
  a_capture: assert property (p_capture) else $error("rising capture missed");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
      !pop |=> $stable(st_ff.rise_stage_reg) && $stable(st_ff.second_cap);
  endproperty
  a_hold: assert property (p_hold) else $error("stage changed without pop");

  property p_fall_stage;
    @(negedge core_clk) disable iff (rst)
      1'h1 |=> (fst_ff.fall_stage_reg == $past(st_ff.second_cap));
  endproperty
  a_fall_stage: assert property (p_fall_stage) else $error("fall stage not loaded");

  property p_mux_high;
    @(negedge core_clk) disable iff (rst)
      (mode == IOR_DDR) |-> (pad_data_out == st_ff.rise_stage_reg);
  endproperty
  a_mux_high: assert property (p_mux_high) else $error("ddr high phase wrong");

  property p_mux_low;
    @(posedge core_clk) disable iff (rst)
      (mode == IOR_DDR) |-> (pad_data_out == fst_ff.fall_stage_reg);
  endproperty
  a_mux_low: assert property (p_mux_low) else $error("ddr low phase wrong");

  property p_tri;
    @(posedge core_clk) disable iff (rst)
      pop |=> (pad_oe_n == $past(head[BIT_TRI]));
  endproperty
  a_tri: assert property (p_tri) else $error("tri-state not registered");

  property p_pair;
    @(posedge core_clk) disable iff (rst)
      comp_pair_en |-> (pad_data_n_out != pad_data_out);
  endproperty
  a_pair: assert property (p_pair) else $error("pair not complementary");

  property p_same_edge;
    @(posedge core_clk) disable iff (rst)
      $changed(pad_oe_n) |-> $past(pop);
  endproperty
  a_same_edge: assert property (p_same_edge) else $error("enable moved without data");

  // pop in flip-flop mode, mode still flip-flop one edge later
  sequence s_ff_pop;
    (pop && (mode == IOR_SDR_FF)) ##1 (mode == IOR_SDR_FF);
  endsequence

  property p_sdr_load;
    @(posedge core_clk) disable iff (rst)
      s_ff_pop |-> (pad_data_out == $past(head[BIT_FIRST]));
  endproperty
  a_sdr_load: assert property (p_sdr_load) else $error("sdr pad not loaded from head");
endmodule
`default_nettype wire

// *** logic/ior_pkg.sv ***
// constants and types shared by the output register cell
package ior_pkg;
  // ************************************************
  // word layout and sizes
  // ************************************************
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W = 3;
  localparam int BIT_FIRST = 0;
  localparam int BIT_SECOND = 1;
  localparam int BIT_TRI = 2;
  // ************************************************
  // values after reset
  // ************************************************
  localparam logic RST_DATA = 1'h0;
  localparam logic RST_TRI = 1'h1;
  // ************************************************
  // storage modes
  // ************************************************
  typedef enum logic [1:0] {IOR_SDR_FF, IOR_SDR_LATCH, IOR_DDR} ior_mode_t;
endpackage

// *** logic/ior_fifo.sv ***
// parameterised word fifo in front of the output registers
`timescale 1ns/1ps
`default_nettype none
module ior_fifo #(
  parameter int WIDTH = ior_pkg::WORD_W,
  parameter int DEPTH = ior_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  import ior_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  // ************************************************
  // parameter check
  // ************************************************
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
      $error("ior_fifo needs a power of two depth of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic ready;
    logic valid;
  } ior_fifo_st_t;

  ior_fifo_st_t st_ff;
  ior_fifo_st_t nxt_st;
  logic push;
  logic pop;

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    nxt_st = st_ff;
    push = in_valid & st_ff.ready;
    pop = st_ff.valid & out_ready;
    if (push) begin
      nxt_st.mem[st_ff.wr_ptr] = in_data;
      nxt_st.wr_ptr = st_ff.wr_ptr + AW'(1);
    end
    if (pop) begin
      nxt_st.rd_ptr = st_ff.rd_ptr + AW'(1);
    end
    if (push && !pop) begin
      nxt_st.count = st_ff.count + (AW + 1)'(1);
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - (AW + 1)'(1);
    end
    nxt_st.ready = (nxt_st.count != FULL_CNT);
    nxt_st.valid = (nxt_st.count != '0);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.ready <= 1'h1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready = st_ff.ready;
  assign out_valid = st_ff.valid;
  assign out_data = st_ff.mem[st_ff.rd_ptr];
endmodule
`default_nettype wire

// *** sim/ior_pad_model.sv ***
// pad buffer model fed by the output register cell
`timescale 1ns/1ps
`default_nettype none
module ior_pad_model (
  input wire logic pad_data_out,
  input wire logic pad_data_n_out,
  input wire logic pad_oe_n,
  output logic pad_p,
  output logic pad_n
);
  // ************************************************
  // released pad is pulled up
  // ************************************************
  assign pad_p = pad_oe_n ? 1'h1 : pad_data_out;
  assign pad_n = pad_oe_n ? 1'h1 : pad_data_n_out;
endmodule
`default_nettype wire

// *** sim/io_output_register_test.sv ***
// self-checking bench for the output register cell
`timescale 1ns/1ps
`default_nettype none
module io_output_register_test;
  import ior_pkg::*;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  ior_mode_t mode = IOR_SDR_FF;
  logic comp_pair_en = 1'h0;
  logic in_valid = 1'h0;
  logic out_hold = 1'h0;
  logic [2:0] word = 3'h4;
  wire logic in_ready, pad_data_out, pad_data_n_out, pad_oe_n, pad_p, pad_n;
  int failures = 0;
  int n_compared = 0;
  always #25 core_clk = ~core_clk;
  ior_out_cell DUT (.core_clk(core_clk), .rst(rst), .mode(mode), .comp_pair_en(comp_pair_en),
    .first_data_in(word[0]), .second_data_in(word[1]), .tristate_ctrl_in(word[2]),
    .in_valid(in_valid), .in_ready(in_ready), .out_hold(out_hold), .pad_data_out(pad_data_out),
    .pad_data_n_out(pad_data_n_out), .pad_oe_n(pad_oe_n));
  ior_pad_model pad (.pad_data_out(pad_data_out), .pad_data_n_out(pad_data_n_out),
    .pad_oe_n(pad_oe_n), .pad_p(pad_p), .pad_n(pad_n));
  // ************************************************
  // shared tasks
  // ************************************************
  task check(input string what, input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task print_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task wait_ready;
    int i;
    for (i = 0; i < 20 && in_ready !== 1'h1; i++) @(posedge core_clk);
    if (in_ready !== 1'h1) begin
      failures++;
      print_verdict();
    end
  endtask
  // word is {tri,second,first}; staged one edge after take
  task send(input logic [2:0] w);
    wait_ready();
    @(posedge core_clk);
    in_valid <= 1'h1;
    word <= w;
    @(posedge core_clk);
    in_valid <= 1'h0;
    repeat (3) @(posedge core_clk);
    #10;
  endtask
  // ************************************************
  // scenarios
  // ************************************************
  task test_sdr;
    send(3'h1);
    check("pad", pad_data_out, 1'h1);
    check("oe_n", pad_oe_n, 1'h0);
    check("n out", pad_data_n_out, 1'h0);
    @(posedge core_clk);
    comp_pair_en <= 1'h1;
    send(3'h4);
    check("pad", pad_p, 1'h1);
    check("oe_n", pad_oe_n, 1'h1);
    check("pad", pad_data_out, 1'h0);
    check("n out", pad_data_n_out, 1'h1);
    $display("test sdr done");
  endtask
  task test_ddr;
    int i;
    @(posedge core_clk);
    mode <= IOR_DDR;
    for (i = 1; i < 3; i++) begin
      send(i[2:0]);
      check("high half", pad_data_out, i[0]);
      check("n high", pad_n, ~i[0]);
      @(negedge core_clk);
      #10;
      check("low half", pad_data_out, i[1]);
      @(posedge core_clk);
      #10;
      check("next high", pad_data_out, i[0]);
    end
    $display("test ddr done");
  endtask
  task test_latch;
    @(posedge core_clk);
    mode <= IOR_SDR_LATCH;
    send(3'h1);
    check("latch", pad_data_out, 1'h1);
    @(negedge core_clk);
    #10;
    check("latch hold", pad_data_out, 1'h1);
    send(3'h0);
    check("latch", pad_data_out, 1'h0);
    // latch opens in the pop cycle, one cycle before a flip-flop would load
    @(posedge core_clk);
    in_valid <= 1'h1;
    word <= 3'h1;
    @(posedge core_clk);
    in_valid <= 1'h0;
    #10;
    check("latch open", pad_data_out, 1'h1);
    $display("test latch done");
  endtask
  task test_fill;
    int i;
    @(posedge core_clk);
    mode <= IOR_SDR_FF;
    out_hold <= 1'h1;
    for (i = 0; i < FIFO_DEPTH; i++) begin
      @(posedge core_clk);
      in_valid <= 1'h1;
      word <= (i == FIFO_DEPTH - 1) ? 3'h1 : 3'h4;
    end
    @(posedge core_clk);
    word <= 3'h4;
    @(posedge core_clk);
    #1;
    check("full ready", in_ready, 1'h0);
    check("held pad", pad_data_out, 1'h1);
    check("held oe_n", pad_oe_n, 1'h0);
    @(posedge core_clk);
    in_valid <= 1'h0;
    out_hold <= 1'h0;
    repeat (FIFO_DEPTH + 4) @(posedge core_clk);
    #10;
    check("last pad", pad_data_out, 1'h1);
    check("last oe_n", pad_oe_n, 1'h0);
    wait_ready();
    $display("test fill done");
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    #10;
    check("reset oe_n", pad_oe_n, 1'h1);
    check("reset pad", pad_data_out, 1'h0);
    test_sdr();
    test_ddr();
    test_latch();
    test_fill();
    print_verdict();
  end
endmodule
`default_nettype wire
